//--- dv/pgm_host_model.sv
// far side: the processor reset line fed by the power-good pin
`timescale 1ns/1ps
`default_nettype none
module pgm_host_model (
    input wire logic pg_pin_out,
    input wire logic pg_pin_oe_n,
    output logic     pg_wire
);
    // ------------------------------------------------------------
    // board line
    // ------------------------------------------------------------
    // pull-up on the board lifts the line once the pin lets go
    assign pg_wire = pg_pin_oe_n ? 1'b1 : pg_pin_out;
endmodule
`default_nettype wire

//--- dv/pgm_power_good_sva.sv
// checker: port-level properties of the power-good monitor
`timescale 1ns/1ps
`default_nettype none
module pgm_power_good_sva
    import pgm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pg_pin_out,
    input wire logic        pg_pin_oe_n
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("no bvalid");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    b_block_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no rvalid");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    rd_unmap_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > PGM_STATUS_ADDR |=> s_axi_rresp == PGM_RESP_SLVERR
        && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
    od_release_a: assert property (pg_pin_oe_n |-> pg_pin_out)
        else $error("released while low");
    init_active_a: assert property ($rose(rst_n) |->
        pg_pin_out && !pg_pin_oe_n) else $error("not active at start");
endmodule

bind pgm_power_good pgm_power_good_sva u_sva (.*);
`default_nettype wire

//--- dv/test_power_good_monitor.sv
// testbench: register and pin scenarios for the power-good monitor
`timescale 1ns/1ps
`default_nettype none
module test_power_good_monitor
    import pgm_pkg::*;
#(parameter int HC = 20);
    // ------------------------------------------------------------
    // stimulus and tasks
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, pol = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic pg_pin_out, pg_pin_oe_n, pg_wire;
    pgm_rail_t rails = 16'hFFF0;
    logic dual_phase = 1'b0, seq_step = 1'b0, twarn = 1'b0;
    logic ovp = 1'b0, tsd = 1'b0;
    int err_total = 0, n_tests = 0;

    always #4 clk = ~clk;

    pgm_power_good #(.HOLD_CYCLES(HC), .MODE_DEFAULT(1'b0)) dut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rails(rails), .dual_phase(dual_phase),
        .seq_step(seq_step), .thermal_warning_status(twarn),
        .ovp_event(ovp), .tsd_event(tsd), .pg_pin_in(pg_wire),
        .pg_pin_out(pg_pin_out), .pg_pin_oe_n(pg_pin_oe_n));

    pgm_host_model host (.*);

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // decision is registered: look one edge later
    task automatic chk_pin(input logic exp);
        @(posedge clk) @(negedge clk);
        n_tests++;
        if (pg_wire !== (exp ^ pol)) begin
            err_total++;
            $display("Error %0t: pin level %b", $time, pg_wire);
        end
    endtask

    task automatic tmo(input int n);
        if (n > 200) begin
            err_total++;
            $display("Error %0t: no bus answer", $time);
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = PGM_RESP_OKAY);
        int n = 0;
        logic ta, tw, tb, done = 1'b0;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF;
        wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) chk({30'h0, bresp}, {30'h0, er});
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                done = 1'b1;
            end
            n++;
            tmo(n);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
        int n = 0;
        logic tr, tb, done = 1'b0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            tr = arvalid && arready;
            tb = rvalid && rready;
            if (tb) chk(rdata & m, exp);
            @(posedge clk);
            if (tr) arvalid <= 1'b0;
            if (tb) begin
                rready <= 1'b0;
                done = 1'b1;
            end
            n++;
            tmo(n);
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rchk(PGM_CTRL_ONE_ADDR, 32'hFFFF_FFFF, PGM_C1_RST);
        rchk(PGM_CTRL_TWO_ADDR, 32'h0000_0002, 32'h0000_0000);
        rchk(PGM_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
        wr(PGM_CTRL_TWO_ADDR, 32'h0000_0002);
        @(posedge clk) rails.uv_ok[2] <= 1'b0;
        chk_pin(1'b0);
        rchk(PGM_STATUS_ADDR, 32'h0000_0001, 32'h0000_0000);
        @(posedge clk) rails.uv_ok[2] <= 1'b1;
        chk_pin(1'b1);
        rchk(PGM_FAULT_ADDR, 32'h0000_000F, 32'h0000_0004);
        wr(PGM_FAULT_ADDR, 32'h0000_0004);
        rchk(PGM_FAULT_ADDR, 32'h0000_000F, 32'h0000_0000);
        @(posedge clk) rails.ov_ok[0] <= 1'b0;
        chk_pin(1'b1);
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_001F);
        chk_pin(1'b0);
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_000F);
        @(posedge clk) rails.ov_ok[0] <= 1'b1;
        @(posedge clk) rails.enabled[3] <= 1'b0;
        rails.uv_ok[3] <= 1'b0;
        chk_pin(1'b1);
        @(posedge clk) rails.uv_ok[3] <= 1'b1;
        @(posedge clk) rails.enabled[3] <= 1'b1;
        @(posedge clk) dual_phase <= 1'b1;
        rails.uv_ok[1] <= 1'b0;
        chk_pin(1'b1);
        @(posedge clk) dual_phase <= 1'b0;
        chk_pin(1'b0);
        @(posedge clk) rails.uv_ok[1] <= 1'b1;
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_000E);
        @(posedge clk) rails.uv_ok[0] <= 1'b0;
        chk_pin(1'b1);
        @(posedge clk) rails.uv_ok[0] <= 1'b1;
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_000F);
        @(posedge clk) twarn <= 1'b1;
        chk_pin(1'b1);
        wr(PGM_CTRL_TWO_ADDR, 32'h0000_0003);
        chk_pin(1'b0);
        @(posedge clk) twarn <= 1'b0;
        chk_pin(1'b1);
        @(posedge clk) rails.ramping[0] <= 1'b1;
        chk_pin(1'b0);
        @(posedge clk) rails.ramping[0] <= 1'b0;
        chk_pin(1'b1);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) {tsd, ovp} <= 2'b01 << i;
            @(posedge clk) {tsd, ovp} <= 2'b00;
            chk_pin(1'b0);
            rchk(PGM_FLAGS_ADDR, 32'h0000_0007, 32'h4 | (32'h1 << i));
            wr(PGM_FLAGS_ADDR, 32'h1 << i);
            chk_pin(1'b1);
        end
        wr(PGM_FAULT_ADDR, 32'h0000_000F);
        wr(PGM_CTRL_TWO_ADDR, 32'h0000_0006);
        @(posedge clk) rails.uv_ok[0] <= 1'b0;
        @(posedge clk) rails.uv_ok[0] <= 1'b1;
        chk_pin(1'b0);
        wr(PGM_FAULT_ADDR, 32'h0000_000F);
        chk_pin(1'b1);
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_010F);
        pol = 1'b1;
        chk_pin(1'b1);
        rchk(PGM_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_030F);
        chk_pin(1'b1);
        @(posedge clk) rails.uv_ok[0] <= 1'b0;
        chk_pin(1'b0);
        @(posedge clk) rails.uv_ok[0] <= 1'b1;
        wr(PGM_FAULT_ADDR, 32'h0000_000F);
        wr(PGM_CTRL_ONE_ADDR, 32'h0000_000F);
        pol = 1'b0;
        wr(PGM_CTRL_TWO_ADDR, 32'h0000_0000);
        @(posedge clk) seq_step <= 1'b1;
        @(posedge clk) seq_step <= 1'b0;
        repeat (HC - 5) @(posedge clk);
        seq_step <= 1'b1;
        @(posedge clk) seq_step <= 1'b0;
        rails.uv_ok[3] <= 1'b0;
        repeat (10) @(posedge clk);
        chk_pin(1'b1);
        rchk(PGM_STATUS_ADDR, 32'h0000_0004, 32'h0000_0004);
        repeat (HC) @(posedge clk);
        chk_pin(1'b0);
        @(posedge clk) rails.uv_ok[3] <= 1'b1;
        chk_pin(1'b0);
        wr(PGM_FAULT_ADDR, 32'h0000_000F);
        chk_pin(1'b1);
        wr(8'h14, 32'h0000_0001, PGM_RESP_SLVERR);
        rchk(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
        final_report();
    end
endmodule
`default_nettype wire

//--- rtl/pgm_pkg.sv
// package: register map, field positions, timing constants for the monitor
package pgm_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PGM_CTRL_ONE_ADDR  = 8'h00;
    localparam logic [7:0] PGM_CTRL_TWO_ADDR  = 8'h04;
    localparam logic [7:0] PGM_FAULT_ADDR     = 8'h08;
    localparam logic [7:0] PGM_FLAGS_ADDR     = 8'h0C;
    localparam logic [7:0] PGM_STATUS_ADDR    = 8'h10;
    // ------------------------------------------------------------
    // pg_control_one fields
    // ------------------------------------------------------------
    localparam int PGM_C1_BUCK_SEL  = 0;  // 2 bits
    localparam int PGM_C1_LIN_SEL   = 2;  // 2 bits
    localparam int PGM_C1_WIN       = 4;  // 4 bits, one per rail
    localparam int PGM_C1_POL       = 8;
    localparam int PGM_C1_OD        = 9;
    localparam logic [31:0] PGM_C1_RST = 32'h0000_000F;
    // ------------------------------------------------------------
    // pg_control_two fields
    // ------------------------------------------------------------
    localparam int PGM_C2_TWARN     = 0;
    localparam int PGM_C2_MODE      = 1;
    localparam int PGM_C2_HOLD      = 2;
    localparam logic [31:0] PGM_C2_RST = 32'h0000_0000;
    // flags register: overvoltage, thermal shutdown and power-good interrupt
    localparam int PGM_FL_OVP       = 0;
    localparam int PGM_FL_TSD       = 1;
    localparam int PGM_FL_PGINT     = 2;
    // status register
    localparam int PGM_ST_PG        = 0;
    localparam int PGM_ST_PGINT     = 1;
    localparam int PGM_ST_HOLD      = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PGM_CLK_MHZ      = 125;
    localparam int PGM_HOLD_US      = 800;
    localparam int PGM_HOLD_CYC     = PGM_HOLD_US * PGM_CLK_MHZ;
    localparam logic [1:0] PGM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] PGM_RESP_SLVERR = 2'b10;

    // analog per-rail monitor results
    typedef struct packed {
        logic [3:0] enabled;    // regulator enabled
        logic [3:0] uv_ok;      // above undervoltage limit
        logic [3:0] ov_ok;      // below overvoltage limit
        logic [3:0] ramping;    // moving between targets
    } pgm_rail_t;

    typedef enum logic [1:0] {
        PGM_ST_INIT  = 2'b00,
        PGM_ST_RUN   = 2'b01,
        PGM_ST_WAIT  = 2'b11
    } pgm_state_t;
endpackage

//--- rtl/pgm_power_good.sv
// power-good aggregation with AXI4-Lite control registers
//
// Overview of operation
// - status bit reads 1 whenever the pin shows valid voltages, any polarity.
// - polarity bit inverts only the pin; status and interrupt keep fixed sense.
// - each buck and linear rail individually selectable; dual-phase uses master.
// - disabled regulator's monitor is masked automatically.
// - separate enable adds the thermal warning status as a source.
// - output active only when every selected source reports valid.
// - window bit 0 checks undervoltage; 1 checks under and overvoltage.
// - configuration bits choose pin polarity and push-pull or open-drain.
// - mode bit loaded from defaults; 0 gated, 1 continuous.
// - gated: start active, freeze status 800 us on sequencing or changes.
// - gated: after hold-off, go inactive if any output out of range.
// - gated: each fault sets own bit; monitoring waits until cleared.
// - host clears rail faults and interrupt flags by writing 1.
// - continuous: start active, inactive once a regulator enables, then track.
// - continuous: toggle with range status during sequencing and changes.
// - fault bits latch until host writes 1.
// - continuous: inactive while a selected regulator ramps between targets.
// - continuous: valid again returns output active unless fault gating enabled.
// - fault gating holds output inactive while any fault bit pending.
`timescale 1ns/1ps
`default_nettype none
module pgm_power_good
    import pgm_pkg::*;
#(
    parameter int HOLD_CYCLES = PGM_HOLD_CYC,
    parameter logic MODE_DEFAULT = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire pgm_rail_t   rails,
    input  wire logic        dual_phase,
    input  wire logic        seq_step,
    input  wire logic        thermal_warning_status,
    input  wire logic        ovp_event,
    input  wire logic        tsd_event,
    input  wire logic        pg_pin_in,
    output logic             pg_pin_out,
    output logic             pg_pin_oe_n
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    generate
        if (HOLD_CYCLES < 1 || HOLD_CYCLES > 32'h00FF_FFFF) begin : g_chk
            $error("hold cycles out of range");
        end
    endgenerate

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] pg_control_one_ff;
    logic [31:0] pg_control_two_ff;
    logic [3:0]  rail_fault_latch_register_ff;
    logic        input_overvoltage_flag_ff;
    logic        thermal_shutdown_flag_ff;
    logic        pg_interrupt_flag_ff;
    logic        mode_loaded_ff;
    logic        power_good_ff;
    logic        pg_prev_ff;
    logic [23:0] hold_cnt_ff;
    logic [3:0]  en_prev_ff;
    pgm_state_t  state_ff;

    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == PGM_CTRL_ONE_ADDR) || (a == PGM_CTRL_TWO_ADDR)
                  || (a == PGM_FAULT_ADDR) || (a == PGM_FLAGS_ADDR)
                  || (a == PGM_STATUS_ADDR);
    endfunction

    // ------------------------------------------------------------
    // axi write path: address and data taken in either order
    // ------------------------------------------------------------
    logic do_write;
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= PGM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= addr_known(awaddr_ff) ? PGM_RESP_OKAY
                                                    : PGM_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // byte-lane merge for the control registers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    logic wr_c1, wr_c2, wr_flt, wr_flg;
    assign wr_c1  = do_write && awaddr_ff == PGM_CTRL_ONE_ADDR;
    assign wr_c2  = do_write && awaddr_ff == PGM_CTRL_TWO_ADDR;
    assign wr_flt = do_write && awaddr_ff == PGM_FAULT_ADDR && wstrb_ff[0];
    assign wr_flg = do_write && awaddr_ff == PGM_FLAGS_ADDR && wstrb_ff[0];

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_control_one_ff <= PGM_C1_RST;
            pg_control_two_ff <= PGM_C2_RST;
            mode_loaded_ff    <= 1'b0;
        end else begin
            // defaults load once after release, as a one-time image would
            if (!mode_loaded_ff) begin
                mode_loaded_ff                 <= 1'b1;
                pg_control_two_ff[PGM_C2_MODE] <= MODE_DEFAULT;
            end else if (wr_c2) begin
                pg_control_two_ff <= merge(pg_control_two_ff, wdata_ff,
                                           wstrb_ff) & 32'h0000_0007;
            end
            if (wr_c1) begin
                pg_control_one_ff <= merge(pg_control_one_ff, wdata_ff,
                                           wstrb_ff) & 32'h0000_03FF;
            end
        end
    end

    logic       gated_mode;
    logic       hold_en;
    logic [3:0] sel;
    logic [3:0] win;
    assign gated_mode = !pg_control_two_ff[PGM_C2_MODE];
    assign hold_en    = pg_control_two_ff[PGM_C2_HOLD];
    assign win        = pg_control_one_ff[PGM_C1_WIN +: 4];
    // rails 0,1 buck, 2,3 linear; slave buck ignored in dual phase
    assign sel = {pg_control_one_ff[PGM_C1_LIN_SEL +: 2],
                  pg_control_one_ff[PGM_C1_BUCK_SEL + 1] & !dual_phase,
                  pg_control_one_ff[PGM_C1_BUCK_SEL]};

    // ------------------------------------------------------------
    // source evaluation
    // ------------------------------------------------------------
    logic [3:0] rail_bad;
    logic       src_bad;
    logic       any_ramp;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_rail
            assign rail_bad[g] = sel[g] && rails.enabled[g]
                && (!rails.uv_ok[g] || (win[g] && !rails.ov_ok[g]));
        end
    endgenerate
    assign any_ramp = |(rails.ramping & rails.enabled & sel);
    assign src_bad  = (|rail_bad)
        || (pg_control_two_ff[PGM_C2_TWARN] && thermal_warning_status)
        || input_overvoltage_flag_ff || thermal_shutdown_flag_ff;

    // ------------------------------------------------------------
    // fault latches and interrupt flags: set beats clear
    // ------------------------------------------------------------
    logic [3:0] fault_set;
    logic       monitor_live;
    assign monitor_live = !gated_mode || state_ff == PGM_ST_RUN;
    assign fault_set    = rail_bad & {4{monitor_live}};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_fault_latch_register_ff <= 4'h0;
        end else begin
            rail_fault_latch_register_ff <= fault_set |
                (rail_fault_latch_register_ff
                 & ~({4{wr_flt}} & wdata_ff[3:0]));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_overvoltage_flag_ff <= 1'b0;
            thermal_shutdown_flag_ff  <= 1'b0;
        end else begin
            input_overvoltage_flag_ff <= ovp_event || (input_overvoltage_flag_ff
                && !(wr_flg && wdata_ff[PGM_FL_OVP]));
            thermal_shutdown_flag_ff <= tsd_event || (thermal_shutdown_flag_ff
                && !(wr_flg && wdata_ff[PGM_FL_TSD]));
        end
    end

    // ------------------------------------------------------------
    // gated hold-off sequencer
    // ------------------------------------------------------------
    logic       restart;
    logic       newly_on;
    assign newly_on = |(rails.enabled & ~en_prev_ff);
    assign restart  = seq_step || newly_on;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= PGM_ST_INIT;
            hold_cnt_ff <= 24'h00_0000;
            en_prev_ff  <= 4'h0;
        end else begin
            en_prev_ff <= rails.enabled;
            case (state_ff)
                PGM_ST_INIT: begin
                    if (mode_loaded_ff) state_ff <= PGM_ST_RUN;
                end
                PGM_ST_RUN: begin
                    if (gated_mode && restart) begin
                        state_ff    <= PGM_ST_WAIT;
                        hold_cnt_ff <= 24'(HOLD_CYCLES - 1);
                    end
                end
                PGM_ST_WAIT: begin
                    if (restart) begin
                        hold_cnt_ff <= 24'(HOLD_CYCLES - 1);
                    end else if (hold_cnt_ff == 24'h00_0000) begin
                        state_ff <= PGM_ST_RUN;
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff - 24'h00_0001;
                    end
                end
                default: state_ff <= PGM_ST_INIT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // power-good decision
    // ------------------------------------------------------------
    logic nxt_power_good;
    logic pending;
    assign pending = |rail_fault_latch_register_ff;
    always_comb begin
        nxt_power_good = power_good_ff;
        if (state_ff == PGM_ST_INIT) begin
            nxt_power_good = 1'b1;
        end else if (gated_mode) begin
            // frozen during hold-off; pending faults stop recovery
            if (state_ff == PGM_ST_RUN) begin
                if (src_bad) nxt_power_good = 1'b0;
                else if (!pending) nxt_power_good = 1'b1;
            end
        end else begin
            nxt_power_good = !src_bad && !any_ramp && !newly_on
                && !(hold_en && pending);
        end
        if (gated_mode && hold_en && pending) nxt_power_good = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_good_ff        <= 1'b1;
            pg_prev_ff           <= 1'b1;
            pg_interrupt_flag_ff <= 1'b0;
        end else begin
            power_good_ff <= nxt_power_good;
            pg_prev_ff    <= power_good_ff;
            // fixed sense: falling edge of internal good, not pin level
            pg_interrupt_flag_ff <= (pg_prev_ff && !power_good_ff)
                || (pg_interrupt_flag_ff
                    && !(wr_flg && wdata_ff[PGM_FL_PGINT]));
        end
    end

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    logic pin_level;
    assign pin_level = power_good_ff ^ pg_control_one_ff[PGM_C1_POL];
    // open drain: drive only the low level, release for high
    assign pg_pin_out  = pin_level;
    assign pg_pin_oe_n = pg_control_one_ff[PGM_C1_OD] && pin_level;

    // ------------------------------------------------------------
    // axi read path
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        pin_good;
    assign pin_good = pg_pin_in ^ pg_control_one_ff[PGM_C1_POL];
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            PGM_CTRL_ONE_ADDR: rd_mux = pg_control_one_ff;
            PGM_CTRL_TWO_ADDR: rd_mux = pg_control_two_ff;
            PGM_FAULT_ADDR:    rd_mux = {28'h000_0000,
                                         rail_fault_latch_register_ff};
            PGM_FLAGS_ADDR:    rd_mux = {29'h0000_0000, pg_interrupt_flag_ff,
                                         thermal_shutdown_flag_ff,
                                         input_overvoltage_flag_ff};
            PGM_STATUS_ADDR:   rd_mux = {29'h0000_0000,
                                         state_ff == PGM_ST_WAIT,
                                         pg_interrupt_flag_ff, pin_good};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !rvalid_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= PGM_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= addr_known(s_axi_araddr) ? PGM_RESP_OKAY
                                                  : PGM_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
endmodule
`default_nettype wire
